// *** hdl/pulse_output_next_data_regs.sv ***
// next-data staging and transfer logic with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module pulse_output_next_data_regs (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// hardware standby clears, software standby does not
	input wire logic hw_standby,
	// timer channel compare-match pulses, one clock each
	input wire logic [3:0] compare_match,
	// pulse output pins
	output logic [7:0] port_a_output_data,
	output logic [7:0] port_b_output_data,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] low_next_data, next_low_next_data;
	logic [7:0] high_next_data, next_high_next_data;
	logic [7:0] low_next_data_enable, next_low_next_data_enable;
	logic [7:0] high_next_data_enable, next_high_next_data_enable;
	logic [7:0] trigger_select_register, next_trigger_select_register;
	logic [7:0] next_port_a_output_data, next_port_b_output_data;
	logic low_shared, high_shared;
	logic [3:0] fire;
	trigger_if trig ();

	// selector sees the live select fields
	assign trig.trigger_select = trigger_select_register;
	assign trig.compare_match = compare_match;
	assign fire = trig.group_fire;

	group_trigger_select u_sel (
		.trig(trig)
	);

	// sharing tracks the select fields every cycle
	assign low_shared = trigger_select_register[1:0] ==
		trigger_select_register[3:2]; // [RULE18]
	assign high_shared = trigger_select_register[5:4] ==
		trigger_select_register[7:6]; // [RULE18]

	////////////////////////////////////////////////////////////////////////
	// axi write channel state
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [15:0] wr_addr, next_wr_addr;
	logic [7:0] wr_byte, next_wr_byte;
	logic wr_lane, next_wr_lane;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic do_write, wr_hit;
	logic next_awready, next_wready;

	// address and data latched independently; response once both held
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_wr_addr = wr_addr;
		next_wr_byte = wr_byte;
		next_wr_lane = wr_lane;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_wr_addr = awaddr[17:2] ;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_wr_byte = wdata[7:0];
			next_wr_lane = wstrb[0];
		end
		do_write = aw_held && w_held && !bvalid;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
		end
		next_awready = !next_aw_held && !(bvalid && !bready);
		next_wready = !next_w_held && !(bvalid && !bready);
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (do_write) begin
			next_bvalid = 1'b1;
			next_bresp = wr_hit ? pulse_out_pkg::AXI_OKAY :
				pulse_out_pkg::AXI_SLVERR;
		end
	end

	// byte address is 4x index; word index kept in wr_addr
	always_comb begin
		unique case (wr_addr)
			pulse_out_pkg::ADDR_HIGH_NEXT_ENABLE,
			pulse_out_pkg::ADDR_LOW_NEXT_ENABLE,
			pulse_out_pkg::ADDR_HIGH_SHARED,
			pulse_out_pkg::ADDR_LOW_SHARED,
			pulse_out_pkg::ADDR_HIGH_GROUP2_SEP,
			pulse_out_pkg::ADDR_LOW_GROUP0_SEP,
			pulse_out_pkg::ADDR_TRIGGER_SELECT,
			pulse_out_pkg::ADDR_PORT_A_DATA,
			pulse_out_pkg::ADDR_PORT_B_DATA: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 16'h0000;
			wr_byte <= 8'h00;
			wr_lane <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			awready <= 1'b0;
			wready <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			wr_addr <= next_wr_addr;
			wr_byte <= next_wr_byte;
			wr_lane <= next_wr_lane;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			awready <= next_awready;
			wready <= next_wready;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register and output update; transfer beats a same-cycle cpu write
	logic sw_we;
	always_comb begin
		sw_we = do_write && wr_lane;
		next_low_next_data = low_next_data;
		next_high_next_data = high_next_data;
		next_low_next_data_enable = low_next_data_enable;
		next_high_next_data_enable = high_next_data_enable;
		next_trigger_select_register = trigger_select_register;
		next_port_a_output_data = port_a_output_data;
		next_port_b_output_data = port_b_output_data;
		if (sw_we) begin
			unique case (wr_addr)
				pulse_out_pkg::ADDR_LOW_NEXT_ENABLE:
					next_low_next_data_enable = wr_byte; // [RULE12]
				pulse_out_pkg::ADDR_HIGH_NEXT_ENABLE:
					next_high_next_data_enable = wr_byte; // [RULE14]
				pulse_out_pkg::ADDR_TRIGGER_SELECT:
					next_trigger_select_register = wr_byte; // [RULE15]
				pulse_out_pkg::ADDR_LOW_SHARED:
					if (low_shared) begin
						next_low_next_data = wr_byte; // [RULE5]
					end else begin
						next_low_next_data[7:4] = wr_byte[7:4]; // [RULE6]
					end
				pulse_out_pkg::ADDR_LOW_GROUP0_SEP:
					if (!low_shared) begin
						next_low_next_data[3:0] = wr_byte[3:0]; // [RULE6]
					end
				pulse_out_pkg::ADDR_HIGH_SHARED:
					if (high_shared) begin
						next_high_next_data = wr_byte; // [RULE9]
					end else begin
						next_high_next_data[7:4] = wr_byte[7:4]; // [RULE10]
					end
				pulse_out_pkg::ADDR_HIGH_GROUP2_SEP:
					if (!high_shared) begin
						next_high_next_data[3:0] = wr_byte[3:0]; // [RULE10]
					end
				pulse_out_pkg::ADDR_PORT_A_DATA:
					next_port_a_output_data = (port_a_output_data &
						low_next_data_enable) |
						(wr_byte & ~low_next_data_enable);
				pulse_out_pkg::ADDR_PORT_B_DATA:
					next_port_b_output_data = (port_b_output_data &
						high_next_data_enable) |
						(wr_byte & ~high_next_data_enable); // [RULE2]
				default: ;
			endcase
		end
		// whole nibble moves on its group pulse, enabled bits only
		for (int g = 0; g < 2; g++) begin
			if (fire[g]) begin
				for (int b = 4*g; b < 4*g+4; b++) begin
					if (low_next_data_enable[b]) begin
						next_port_a_output_data[b] =
							low_next_data[b]; // [RULE3] [RULE11] [RULE17]
					end
				end
			end
			if (fire[g+2]) begin
				for (int b = 4*g; b < 4*g+4; b++) begin
					if (high_next_data_enable[b]) begin
						next_port_b_output_data[b] =
							high_next_data[b]; // [RULE7] [RULE13] [RULE17]
					end
				end
			end
		end
	end

	// hardware standby acts like reset; software standby keeps state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_next_data <= pulse_out_pkg::RESET_NEXT_DATA; // [RULE4]
			high_next_data <= pulse_out_pkg::RESET_NEXT_DATA; // [RULE8]
			low_next_data_enable <= pulse_out_pkg::RESET_ENABLE;
			high_next_data_enable <= pulse_out_pkg::RESET_ENABLE;
			trigger_select_register <= pulse_out_pkg::RESET_TRIGGER_SELECT;
			port_a_output_data <= pulse_out_pkg::RESET_PORT_DATA;
			port_b_output_data <= pulse_out_pkg::RESET_PORT_DATA; // [RULE1]
		end else if (hw_standby) begin
			low_next_data <= pulse_out_pkg::RESET_NEXT_DATA; // [RULE4]
			high_next_data <= pulse_out_pkg::RESET_NEXT_DATA; // [RULE8]
			low_next_data_enable <= pulse_out_pkg::RESET_ENABLE; // [RULE12]
			high_next_data_enable <= pulse_out_pkg::RESET_ENABLE; // [RULE14]
			trigger_select_register <= pulse_out_pkg::RESET_TRIGGER_SELECT;
			port_a_output_data <= pulse_out_pkg::RESET_PORT_DATA;
			port_b_output_data <= pulse_out_pkg::RESET_PORT_DATA; // [RULE1]
		end else begin
			low_next_data <= next_low_next_data;
			high_next_data <= next_high_next_data;
			low_next_data_enable <= next_low_next_data_enable;
			high_next_data_enable <= next_high_next_data_enable;
			trigger_select_register <= next_trigger_select_register;
			port_a_output_data <= next_port_a_output_data;
			port_b_output_data <= next_port_b_output_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel: one read at a time, answer one cycle after accept
	logic next_arready, next_rvalid;
	logic [31:0] next_rdata, rd_value;
	logic [1:0] next_rresp;
	logic rd_hit;
	logic [15:0] rd_addr;

	// reserved nibbles read as ones
	always_comb begin
		rd_addr = araddr[17:2];
		rd_hit = 1'b1;
		rd_value = 32'h00000000;
		unique case (rd_addr)
			pulse_out_pkg::ADDR_LOW_NEXT_ENABLE:
				rd_value[7:0] = low_next_data_enable;
			pulse_out_pkg::ADDR_HIGH_NEXT_ENABLE:
				rd_value[7:0] = high_next_data_enable;
			pulse_out_pkg::ADDR_TRIGGER_SELECT:
				rd_value[7:0] = trigger_select_register;
			pulse_out_pkg::ADDR_PORT_A_DATA:
				rd_value[7:0] = port_a_output_data;
			pulse_out_pkg::ADDR_PORT_B_DATA:
				rd_value[7:0] = port_b_output_data;
			pulse_out_pkg::ADDR_LOW_SHARED:
				rd_value[7:0] = low_shared ? low_next_data :
					{low_next_data[7:4], pulse_out_pkg::RESERVED_NIBBLE};
			pulse_out_pkg::ADDR_LOW_GROUP0_SEP:
				rd_value[7:0] = low_shared ?
					pulse_out_pkg::READ_ALL_ONES[7:0] :
					{pulse_out_pkg::RESERVED_NIBBLE,
					low_next_data[3:0]}; // [RULE5] [RULE6]
			pulse_out_pkg::ADDR_HIGH_SHARED:
				rd_value[7:0] = high_shared ? high_next_data :
					{high_next_data[7:4], pulse_out_pkg::RESERVED_NIBBLE};
			pulse_out_pkg::ADDR_HIGH_GROUP2_SEP:
				rd_value[7:0] = high_shared ?
					pulse_out_pkg::READ_ALL_ONES[7:0] :
					{pulse_out_pkg::RESERVED_NIBBLE,
					high_next_data[3:0]}; // [RULE9] [RULE10]
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_arready = arready;
		if (rvalid && rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = rd_value;
			next_rresp = rd_hit ? pulse_out_pkg::AXI_OKAY :
				pulse_out_pkg::AXI_SLVERR;
		end
		if (!arready && !rvalid && !(arvalid && arready)) begin
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'h0;
		end else begin
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end
endmodule
`default_nettype wire

// *** hdl/pulse_out_pkg.sv ***
// constants and register map of the pulse output next-data block
// Functional notes
// [RULE1] port B output data, 8 bits, reset zero
// [RULE2] enabled port B bits ignore software writes
// [RULE3] low next-data copied to port A on trigger
// [RULE4] low next-data clears on reset and hardware standby
// [RULE5] shared low trigger: byte at first, ones at second
// [RULE6] separate low triggers: nibbles split across addresses
// [RULE7] high next-data copied to port B on trigger
// [RULE8] high next-data clears on reset and hardware standby
// [RULE9] shared high trigger: byte at first, ones at second
// [RULE10] separate high triggers: nibbles split across addresses
// [RULE11] low side copies only enabled bits
// [RULE12] low enable register read/write, clears at reset
// [RULE13] high side copies only enabled bits
// [RULE14] high enable register read/write, clears at reset
// [RULE15] 2-bit field per group selects timer channel
// [RULE16] software sets direction bits for used pins
// [RULE17] compare-match pulse transfers once, whole group together
// [RULE18] sharing decided by comparing paired select fields
package pulse_out_pkg;
	localparam logic [15:0] ADDR_HIGH_NEXT_ENABLE = 16'hFFA2;
	localparam logic [15:0] ADDR_LOW_NEXT_ENABLE = 16'hFFA3;
	localparam logic [15:0] ADDR_HIGH_SHARED = 16'hFFA4;
	localparam logic [15:0] ADDR_LOW_SHARED = 16'hFFA5;
	localparam logic [15:0] ADDR_HIGH_GROUP2_SEP = 16'hFFA6;
	localparam logic [15:0] ADDR_LOW_GROUP0_SEP = 16'hFFA7;
	localparam logic [15:0] ADDR_TRIGGER_SELECT = 16'hFFA1;
	localparam logic [15:0] ADDR_PORT_A_DATA = 16'hFFD3;
	localparam logic [15:0] ADDR_PORT_B_DATA = 16'hFFD6;
	localparam logic [7:0] RESET_NEXT_DATA = 8'h00;
	localparam logic [7:0] RESET_ENABLE = 8'h00;
	localparam logic [7:0] RESET_PORT_DATA = 8'h00;
	localparam logic [7:0] RESET_TRIGGER_SELECT = 8'hFF;
	localparam logic [3:0] RESERVED_NIBBLE = 4'hF;
	localparam logic [31:0] READ_ALL_ONES = 32'h000000FF;
	localparam int GROUPS = 4;
	localparam int SELECT_WIDTH = 2;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// *** hdl/trigger_if.sv ***
// group trigger carrier between register block and trigger selector
`timescale 1ns/100ps
`default_nettype none
interface trigger_if;
	logic [7:0] trigger_select;
	logic [3:0] compare_match;
	logic [3:0] group_fire;
	modport selector(input trigger_select, input compare_match,
		output group_fire);
	modport regs(output trigger_select, output compare_match,
		input group_fire);
endinterface
`default_nettype wire

// *** hdl/group_trigger_select.sv ***
// per-group selection of the timer compare-match pulse
`timescale 1ns/100ps
`default_nettype none
module group_trigger_select (
	// select fields in, group pulses out
	trigger_if.selector trig
);
	// one mux per group, pulse passes straight through
	genvar g;
	generate
		for (g = 0; g < pulse_out_pkg::GROUPS; g++) begin : g_group
			always_comb begin
				trig.group_fire[g] = trig.compare_match[trig.trigger_select[
					pulse_out_pkg::SELECT_WIDTH*g +:
					pulse_out_pkg::SELECT_WIDTH]]; // [RULE15] [RULE17]
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** dv/pulse_out_sva.sv ***
// port-level checks for the next-data block
`timescale 1ns/100ps
`default_nettype none
module pulse_out_sva (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// standby, triggers and pins
	input wire logic hw_standby,
	input wire logic [3:0] compare_match,
	input wire logic [7:0] port_a_output_data,
	input wire logic [7:0] port_b_output_data,
	// bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	// pins move only on a trigger, a write or standby
	a_pin_a_cause: assert property (
		$changed(port_a_output_data) |-> $past(|compare_match)
		|| $rose(bvalid) || $past(hw_standby))
		else $error("port a changed without cause");
	a_pin_b_cause: assert property (
		$changed(port_b_output_data) |-> $past(|compare_match)
		|| $rose(bvalid) || $past(hw_standby))
		else $error("port b changed without cause");
	// standby clears the pin data next edge
	a_standby_clear: assert property (
		hw_standby |=> port_a_output_data == 8'h00
		&& port_b_output_data == 8'h00)
		else $error("pins not cleared by standby");
	// write answer comes within two edges after both halves taken
	a_write_answer: assert property (
		awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response missing");
	a_resp_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	a_read_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	// a second read waits for the first to finish
	a_read_block: assert property (rvalid |-> !arready)
		else $error("read accepted while busy");
	// registers are a byte wide, upper bits read zero
	a_read_width: assert property (
		rvalid && rresp == 2'h0 |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule
`default_nettype wire

// *** dv/timer_match_model.sv ***
// timer compare-match source facing the block
`timescale 1ns/100ps
`default_nettype none
module timer_match_model (
	// clock
	input wire logic clk,
	// compare-match pulses
	output var logic [3:0] compare_match
);
	// idle low between events
	initial compare_match = 4'h0;
	// one single-cycle pulse per call, launched just after an edge
	task automatic fire(input logic [3:0] mask);
		compare_match <= mask;
		@(posedge clk);
		compare_match <= 4'h0;
	endtask
endmodule
`default_nettype wire

// *** dv/pulse_output_next_data_regs_bench.sv ***
// self-checking bench for the next-data block
`timescale 1ns/100ps
`default_nettype none
module pulse_output_next_data_regs_bench;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic hw_standby = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] cm;
	logic [7:0] pa, pb;
	int fail_count = 0, checks_done = 0;
	pulse_output_next_data_regs dut (.clk(clk), .arst_n(arst_n),
		.hw_standby(hw_standby), .compare_match(cm),
		.port_a_output_data(pa), .port_b_output_data(pb),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	timer_match_model tm (.clk(clk), .compare_match(cm));
	// 100 ns clock
	initial forever #50 clk = ~clk;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// write cycle; address and data offered together, held till taken
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		output logic [1:0] r);
		logic ad, dd;
		@(posedge clk);
		awaddr <= {14'h0, a, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		ad = 1'h0;
		dd = 1'h0;
		r = 2'h3;
		// no cycle limit here; only the watchdog ends a hang
		forever begin
			@(posedge clk);
			if (!ad && awready === 1'h1) begin
				ad = 1'h1;
				awvalid <= 1'h0;
			end
			if (!dd && wready === 1'h1) begin
				dd = 1'h1;
				wvalid <= 1'h0;
			end
			if (bvalid === 1'h1) begin
				r = bresp;
				break;
			end
		end
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d,
		output logic [1:0] r);
		logic ad;
		@(posedge clk);
		araddr <= {14'h0, a, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		ad = 1'h0;
		d = 8'h0;
		r = 2'h3;
		// wait for the answer however long the slave takes
		forever begin
			@(posedge clk);
			if (!ad && arready === 1'h1) begin
				ad = 1'h1;
				arvalid <= 1'h0;
			end
			if (rvalid === 1'h1) begin
				d = rdata[7:0];
				r = rresp;
				break;
			end
		end
		rready <= 1'h0;
	endtask
	task automatic wc(input logic [15:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk({30'h0, r}, 32'h0);
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk({24'h0, d}, {24'h0, e});
		chk({30'h0, r}, 32'h0);
	endtask
	// pulse, then let the pin update land
	task automatic fire(input logic [3:0] m);
		tm.fire(m);
		@(posedge clk);
	endtask
	// direction bits sit outside the block; pins are judged as driven
	task automatic pins(input logic [7:0] ea, input logic [7:0] eb);
		chk({24'h0, pa}, {24'h0, ea});
		chk({24'h0, pb}, {24'h0, eb});
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		logic [15:0] a[9] = '{16'hFFA1, 16'hFFA2, 16'hFFA3, 16'hFFA4,
			16'hFFA5, 16'hFFA6, 16'hFFA7, 16'hFFD3, 16'hFFD6};
		logic [7:0] e[9] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
			8'hFF, 8'hFF, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) begin
			rc(a[i], e[i]);
		end
		wc(16'hFFA7, 8'h00);
		wc(16'hFFA6, 8'h00);
		rc(16'hFFA7, 8'hFF);
		rc(16'hFFA6, 8'hFF);
		$display("reset test done");
	endtask
	task automatic t_transfer();
		wc(16'hFFA3, 8'h5A);
		wc(16'hFFA2, 8'hC3);
		rc(16'hFFA3, 8'h5A);
		rc(16'hFFA2, 8'hC3);
		wc(16'hFFA5, 8'hFF);
		wc(16'hFFA4, 8'hFF);
		fire(4'h1);
		pins(8'h00, 8'h00);
		fire(4'h8);
		pins(8'h5A, 8'hC3);
		wc(16'hFFD6, 8'h3C);
		rc(16'hFFD6, 8'hFF);
		// port A enabled bits are guarded the same way
		wc(16'hFFD3, 8'h00);
		rc(16'hFFD3, 8'h5A);
		$display("transfer test done");
	endtask
	task automatic t_separate();
		logic [7:0] ea[4] = '{8'h55, 8'hA5, 8'hA5, 8'hA5};
		logic [7:0] eb[4] = '{8'hFF, 8'hFF, 8'hFC, 8'hBC};
		wc(16'hFFA1, 8'hE4);
		wc(16'hFFA5, 8'hA0);
		wc(16'hFFA7, 8'h05);
		wc(16'hFFA4, 8'hB0);
		wc(16'hFFA6, 8'h0C);
		rc(16'hFFA5, 8'hAF);
		rc(16'hFFA7, 8'hF5);
		rc(16'hFFA4, 8'hBF);
		rc(16'hFFA6, 8'hFC);
		wc(16'hFFA3, 8'hFF);
		wc(16'hFFA2, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			fire(4'h1 << i);
			pins(ea[i], eb[i]);
		end
		$display("separate trigger test done");
	endtask
	task automatic t_unmapped();
		logic [7:0] d;
		logic [1:0] r;
		wr(16'h0000, 8'h12, r);
		chk({30'h0, r}, {30'h0, pulse_out_pkg::AXI_SLVERR});
		rd(16'h0000, d, r);
		chk({30'h0, r}, {30'h0, pulse_out_pkg::AXI_SLVERR});
		$display("unmapped test done");
	endtask
	task automatic t_standby();
		@(posedge clk);
		hw_standby <= 1'h1;
		repeat (2) @(posedge clk);
		hw_standby <= 1'h0;
		@(posedge clk);
		pins(8'h00, 8'h00);
		rc(16'hFFA3, 8'h00);
		rc(16'hFFA2, 8'h00);
		rc(16'hFFA5, 8'h00);
		rc(16'hFFA4, 8'h00);
		rc(16'hFFA1, 8'hFF);
		$display("standby test done");
	endtask
	task automatic conclude();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'h1;
		repeat (2) @(posedge clk);
		t_reset();
		t_transfer();
		t_separate();
		t_unmapped();
		t_standby();
		conclude();
	end
	// watchdog, far beyond the fewer than two hundred cycles needed
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		conclude();
	end
endmodule
bind pulse_output_next_data_regs pulse_out_sva sva (.clk(clk),
	.arst_n(arst_n), .hw_standby(hw_standby),
	.compare_match(compare_match),
	.port_a_output_data(port_a_output_data),
	.port_b_output_data(port_b_output_data),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .rresp(rresp));
`default_nettype wire
